// >>> hdl/pbm_regs.vh
`ifndef PBM_REGS_VH
`define PBM_REGS_VH
// Own dataset advertised by this instrument
`define PBM_OWN_PRIO1     8'h80
`define PBM_OWN_CLASS     8'hF8
`define PBM_OWN_ACCURACY  8'hFE
`define PBM_OWN_VARIANCE  16'hFFFF
`define PBM_OWN_PRIO2     8'h7A
// Protocol version accepted
`define PBM_PTP_VERSION   4'h2
// Message type codes
`define PBM_MSG_SYNC      4'h0
`define PBM_MSG_DLY_REQ   4'h1
`define PBM_MSG_PDLY_REQ  4'h2
`define PBM_MSG_PDLY_RSP  4'h3
`define PBM_MSG_FOLLOW    4'h8
`define PBM_MSG_DLY_RSP   4'h9
`define PBM_MSG_PDLY_FUP  4'hA
`define PBM_MSG_ANNOUNCE  4'hB
`define PBM_MSG_SIGNAL    4'hC
`define PBM_MSG_MGMT      4'hD
// Role codes
`define PBM_ROLE_MASTER   1'b0
`define PBM_ROLE_SLAVE    1'b1
`endif

// >>> hdl/pbm_best_master.v
`timescale 1ns/1ps
`include "pbm_regs.vh"
module pbm_best_master #(
  parameter ID_W = 64
) (
  input  wire            clk_in,
  input  wire            nrst_in,
  // Parsed message header
  input  wire            msg_valid_in,
  input  wire [3:0]      msg_type_in,
  input  wire [3:0]      msg_version_in,
  // Announced candidate dataset
  input  wire [7:0]      ann_prio1_in,
  input  wire [7:0]      ann_class_in,
  input  wire [7:0]      ann_accuracy_in,
  input  wire [15:0]     ann_variance_in,
  input  wire [7:0]      ann_prio2_in,
  input  wire [ID_W-1:0] ann_ident_in,
  // Own administrative settings
  input  wire            own_load_in,
  input  wire [7:0]      own_prio1_in,
  input  wire [7:0]      own_prio2_in,
  input  wire [ID_W-1:0] own_ident_in,
  input  wire            forget_in,
  // Classification pulses
  output reg             msg_event_out,
  output reg             msg_general_out,
  output reg             msg_peer_out,
  output reg             msg_ignored_out,
  output reg             stamp_req_out,
  // Election result and own settings
  output reg             role_slave_out,
  output reg             role_changed_out,
  output reg [ID_W-1:0]  gm_ident_out,
  output reg [7:0]       own_prio1_out,
  output reg [7:0]       own_prio2_out
);

  // Stored foreign dataset and own settings
  // Only the latest accepted announce is kept: one foreign candidate.
  // One slot suffices for an ordinary clock on a single segment;
  // a multi-port clock would need one slot per port.
  reg [7:0]      for_p1_q;
  reg [7:0]      for_cls_q;
  reg [7:0]      for_acc_q;
  reg [15:0]     for_var_q;
  reg [7:0]      for_p2_q;
  reg [ID_W-1:0] for_id_q;
  reg            for_vld_q;
  reg [ID_W-1:0] own_id_q;
  reg            rerun_q;

  // Header decode results, all combinational
  wire ver_ok;
  wire is_event;
  wire is_general;
  wire is_peer;
  wire is_announce;
  reg  own_wins;

  // version two only
  // An older header layout is incompatible, so it is never decoded
  assign ver_ok = (msg_version_in == `PBM_PTP_VERSION);

  // event class decode
  // Only these four need precise ingress instants
  assign is_event = (msg_type_in == `PBM_MSG_SYNC) ||
                    (msg_type_in == `PBM_MSG_DLY_REQ) ||
                    (msg_type_in == `PBM_MSG_PDLY_REQ) ||
                    (msg_type_in == `PBM_MSG_PDLY_RSP);

  // general class decode
  // Content matters here, the arrival instant does not
  assign is_general = (msg_type_in == `PBM_MSG_FOLLOW) ||
                      (msg_type_in == `PBM_MSG_DLY_RSP) ||
                      (msg_type_in == `PBM_MSG_PDLY_FUP) ||
                      (msg_type_in == `PBM_MSG_ANNOUNCE) ||
                      (msg_type_in == `PBM_MSG_SIGNAL) ||
                      (msg_type_in == `PBM_MSG_MGMT);

  // peer delay set flagged
  // Used by peer-to-peer switches; flagged so they can be counted
  assign is_peer = (msg_type_in == `PBM_MSG_PDLY_REQ) ||
                   (msg_type_in == `PBM_MSG_PDLY_RSP) ||
                   (msg_type_in == `PBM_MSG_PDLY_FUP);

  // Announce carries the candidate dataset
  assign is_announce = (msg_type_in == `PBM_MSG_ANNOUNCE);

  // ordered field compare, first difference decides
  // Combinational, so a change of either dataset shows at once
  always @* begin
    if (!for_vld_q) begin
      // No candidate heard: stay master
      own_wins = 1'b1;
    end else if (own_prio1_out != for_p1_q) begin
      // Priority one outranks every quality field
      own_wins = (own_prio1_out < for_p1_q);
    end else if (`PBM_OWN_CLASS != for_cls_q) begin
      own_wins = (`PBM_OWN_CLASS < for_cls_q);
    end else if (`PBM_OWN_ACCURACY != for_acc_q) begin
      // Accuracy only counts once class is equal
      own_wins = (`PBM_OWN_ACCURACY < for_acc_q);
    end else if (`PBM_OWN_VARIANCE != for_var_q) begin
      // Stability estimate, smaller is steadier
      own_wins = (`PBM_OWN_VARIANCE < for_var_q);
    end else if (own_prio2_out != for_p2_q) begin
      // Priority two separates otherwise equal clocks
      own_wins = (own_prio2_out < for_p2_q);
    end else begin
      // identifier tie breaker
      // Equal identifiers keep this clock master
      own_wins = (own_id_q <= for_id_q);
    end
  end

  // Classification outputs
  // One-cycle pulses; bad version or unknown type only ignored
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      // Pulses idle in reset
      msg_event_out   <= 1'b0;
      msg_general_out <= 1'b0;
      msg_peer_out    <= 1'b0;
      msg_ignored_out <= 1'b0;
      stamp_req_out   <= 1'b0;
    end else begin
      msg_event_out   <= msg_valid_in && ver_ok && is_event;
      msg_general_out <= msg_valid_in && ver_ok && is_general;
      msg_peer_out    <= msg_valid_in && ver_ok && is_peer;
      msg_ignored_out <= msg_valid_in && !(ver_ok && (is_event || is_general));
      // two-step: timestamp events only
      // One-step correction is not supported, so general
      // messages never ask for a stamp
      stamp_req_out   <= msg_valid_in && ver_ok && is_event;
    end
  end

  // Own dataset and announce capture
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      // own dataset defaults
      // Foreign slot emptied; own identity zero until loaded
      own_prio1_out <= `PBM_OWN_PRIO1;
      own_prio2_out <= `PBM_OWN_PRIO2;
      own_id_q      <= {ID_W{1'b0}};
      for_p1_q      <= 8'h00;
      for_cls_q     <= 8'h00;
      for_acc_q     <= 8'h00;
      for_var_q     <= 16'h0000;
      for_p2_q      <= 8'h00;
      for_id_q      <= {ID_W{1'b0}};
      for_vld_q     <= 1'b0;
      rerun_q       <= 1'b0;
    end else begin
      rerun_q <= 1'b0;
      // settable 8-bit priorities
      // Load also takes the identifier used as tie breaker
      if (own_load_in) begin
        own_prio1_out <= own_prio1_in;
        own_prio2_out <= own_prio2_in;
        own_id_q      <= own_ident_in;
        rerun_q       <= 1'b1;
      end
      if (msg_valid_in && ver_ok && is_announce) begin
        for_p1_q  <= ann_prio1_in;
        for_cls_q <= ann_class_in;
        for_acc_q <= ann_accuracy_in;
        for_var_q <= ann_variance_in;
        for_p2_q  <= ann_prio2_in;
        for_id_q  <= ann_ident_in;
        for_vld_q <= 1'b1;
        rerun_q   <= 1'b1;
      // Announce wins over a forget in the same cycle
      end else if (forget_in) begin
        // Dropping the candidate makes this clock master again
        for_vld_q <= 1'b0;
        rerun_q   <= 1'b1;
      end
    end
  end

  // role update after rerun
  // Role, grandmaster and change pulse update together
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      // Master role, no grandmaster known
      role_slave_out   <= `PBM_ROLE_MASTER;
      role_changed_out <= 1'b0;
      gm_ident_out     <= {ID_W{1'b0}};
    end else begin
      role_changed_out <= 1'b0;
      if (rerun_q) begin
        role_slave_out   <= !own_wins;
        gm_ident_out     <= own_wins ? own_id_q : for_id_q;
        // Pulse compares the new role with the one held
        role_changed_out <= (role_slave_out != !own_wins);
      end
    end
  end

endmodule

// >>> verif/pbm_best_master_sva.sv
`timescale 1ns/1ps
module pbm_best_master_sva #(parameter ID_W = 64) (
  input wire logic            clk_in, nrst_in, msg_valid_in, forget_in,
  input wire logic            own_load_in, msg_event_out, msg_general_out,
  input wire logic            msg_peer_out, msg_ignored_out, stamp_req_out,
  input wire logic            role_slave_out, role_changed_out,
  input wire logic [3:0]      msg_type_in, msg_version_in,
  input wire logic [7:0]      ann_prio1_in, own_prio1_in, own_prio2_in,
  input wire logic [7:0]      own_prio1_out, own_prio2_out,
  input wire logic [ID_W-1:0] ann_ident_in, gm_ident_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Accepted header of the supported version
  wire ok = msg_valid_in && msg_version_in == 4'h2;
  wire ann = ok && msg_type_in == 4'hB;
  AST_EVT: assert property (ok && msg_type_in < 4'h4 |=>
    msg_event_out && stamp_req_out) else $error("event not flagged");
  AST_GEN: assert property (ok && msg_type_in inside {[4'h8:4'hD]} |=>
    msg_general_out && !stamp_req_out) else $error("general not flagged");
  AST_PEER: assert property (ok && msg_type_in inside {2, 3, 10} |=>
    msg_peer_out) else $error("peer delay not flagged");
  AST_VER: assert property (msg_valid_in && msg_version_in != 4'h2 |=>
    msg_ignored_out && !msg_event_out && !msg_general_out)
    else $error("old version used");
  AST_IDLE: assert property (!msg_valid_in |=> !msg_event_out &&
    !msg_general_out && !msg_ignored_out) else $error("pulse when idle");
  AST_LOAD: assert property (own_load_in |=>
    own_prio1_out == $past(own_prio1_in) &&
    own_prio2_out == $past(own_prio2_in)) else $error("priority not loaded");
  AST_CHG: assert property (role_changed_out |->
    role_slave_out != $past(role_slave_out)) else $error("bad role change");
  AST_FGT: assert property (forget_in && !ann |=> ##1 !role_slave_out)
    else $error("forget kept slave role");
  AST_WIN: assert property (ann && ann_prio1_in < own_prio1_out |=> ##1
    role_slave_out && gm_ident_out == $past(ann_ident_in, 2))
    else $error("better clock not followed");
  // Main scenarios reached
  cover property (role_changed_out && role_slave_out);
  cover property (msg_ignored_out);
  cover property (msg_peer_out && stamp_req_out);
endmodule

// >>> verif/pbm_peer_clock.sv
`timescale 1ns/1ps
module pbm_peer_clock (
  input  wire logic    clk_in,
  output logic         valid_out = 1'b0,
  output logic [3:0]   type_out = 4'h0,
  output logic [3:0]   ver_out = 4'h2,
  output logic [111:0] ds_out = '0
);
  // An upstream boundary clock passes only its chosen master
  // Correction updates happen upstream of this header view
  // so the dataset and identity arrive unchanged
  // Header with dataset and identity, held one cycle
  task send(input logic [3:0] t, v, input logic [111:0] d);
    @(posedge clk_in);
    valid_out <= 1'b1;
    type_out <= t;
    ver_out <= v;
    ds_out <= d;
    @(posedge clk_in);
    valid_out <= 1'b0;
    ds_out <= ~d; // Released lines do not keep the value
  endtask
endmodule

// >>> verif/pbm_best_master_tb.sv
`timescale 1ns/1ps
module pbm_best_master_tb;
  logic clk_in = 0, nrst_in = 0, own_load_in = 0, forget_in = 0;
  logic [7:0] own_prio1_in = 8'h80, own_prio2_in = 8'h7A;
  logic [63:0] own_ident_in = 64'h0;
  wire msg_valid_in, msg_event_out, msg_general_out, msg_peer_out;
  wire msg_ignored_out, stamp_req_out, role_slave_out, role_changed_out;
  wire [3:0] msg_type_in, msg_version_in;
  wire [7:0] ann_prio1_in, ann_class_in, ann_accuracy_in, ann_prio2_in;
  wire [7:0] own_prio1_out, own_prio2_out;
  wire [15:0] ann_variance_in;
  wire [63:0] ann_ident_in, gm_ident_out;
  logic [111:0] own = {32'h80F8FEFF, 16'hFF7A, 64'h0}, fd;
  logic have = 0, ps = 0;
  int n_mismatch = 0, checks_done = 0, cyc = 0, pos[6] = '{104,96,88,72,64,0};
  always #4 clk_in = ~clk_in;
  pbm_peer_clock peer_u (.clk_in(clk_in), .valid_out(msg_valid_in),
    .type_out(msg_type_in), .ver_out(msg_version_in), .ds_out({ann_prio1_in,
    ann_class_in, ann_accuracy_in, ann_variance_in, ann_prio2_in,
    ann_ident_in}));
  pbm_best_master dut_u (.*);
  // Expected class pulses
  function logic [4:0] cls(input logic [3:0] t, v);
    logic e, g;
    e = v == 4'h2 && t < 4'h4;
    g = v == 4'h2 && t inside {[4'h8:4'hD]};
    return {e, g, v == 4'h2 && t inside {2, 3, 10}, !(e || g), e};
  endfunction
  task chk(input logic [111:0] g, e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rchk;
    logic es;
    es = have && fd < own;
    chk({role_changed_out, role_slave_out, gm_ident_out},
      {es != ps, es, es ? fd[63:0] : own[63:0]});
    ps = es;
  endtask
  task msg(input logic [3:0] t, v, input logic [111:0] d);
    peer_u.send(t, v, d);
    #1 chk({msg_event_out, msg_general_out, msg_peer_out, msg_ignored_out,
      stamp_req_out}, cls(t, v));
    if (v == 4'h2 && t == 4'hB) begin
      fd = d;
      have = 1;
    end
    @(posedge clk_in);
    #1 rchk;
  endtask
  // Own priority load or foreign dataset drop
  task ctl(input logic ld, fg, input logic [7:0] a, b, input logic [63:0] i);
    @(posedge clk_in);
    own_load_in <= ld;
    forget_in <= fg;
    own_prio1_in <= a;
    own_prio2_in <= b;
    own_ident_in <= i;
    @(posedge clk_in);
    own_load_in <= 0;
    forget_in <= 0;
    if (ld) own = {a, 32'hF8FEFFFF, b, i};
    if (fg) have = 0;
    #1 chk({own_prio1_out, own_prio2_out}, own[111:104] << 8 | own[71:64]);
    @(posedge clk_in);
    #1 rchk;
  endtask
  task complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      complete_run;
    end
  end
  initial begin
    void'($urandom(35));
    repeat (12) @(posedge clk_in);
    nrst_in <= 1;
    #1 chk({own_prio1_out, own_prio2_out, role_slave_out}, 17'h1_00F4);
    for (int t = 0; t < 16; t++) msg(t[3:0], 4'h2, own);
    msg(4'h0, 4'h1, 0);
    msg(4'hB, 4'h1, 0);
    ctl(1, 0, 8'h80, 8'h7A, 64'h5);
    msg(4'hB, 4'h2, {32'h80F8FEFF, 16'hFF80, 64'h1});
    for (int i = 0; i < 6; i++) begin
      msg(4'hB, 4'h2, own - (112'h1 << pos[i]));
      msg(4'hB, 4'h2, own);
    end
    repeat (60) begin
      case ($urandom_range(5))
        0: ctl(1, 0, 8'($urandom_range(127, 129)), 8'($urandom_range(121, 123)),
          64'($urandom_range(4, 6)));
        1: ctl(0, 1, own_prio1_in, own_prio2_in, own_ident_in);
        default: msg(4'hB, 4'h2, own + (112'($urandom_range(2)) <<
          pos[$urandom_range(5)]) - (112'h1 << pos[$urandom_range(5)]));
      endcase
    end
    complete_run;
  end
endmodule
bind pbm_best_master pbm_best_master_sva #(.ID_W(ID_W)) sva_u (.*);
